//--- core/slbc_err_counter.sv
// saturating forward-link error counter
// assumes clear and increment come from logic on the same clock
`default_nettype none

module slbc_err_counter (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic clear_i,
    input wire logic inc_i,
    output logic [slbc_pkg::CNT_W-1:0] count_o
);

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    // saturate rather than wrap so a long bad run never reads as clean
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_o <= slbc_pkg::CNT_RESET;
        end else if (ce_i) begin
            if (clear_i) begin
                count_o <= slbc_pkg::CNT_RESET;
            end else if (inc_i && count_o != slbc_pkg::CNT_MAX) begin
                count_o <= count_o + slbc_pkg::CNT_ONE;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    cnt_step_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && !clear_i && inc_i && count_o != slbc_pkg::CNT_MAX
        |=> count_o == $past(count_o) + slbc_pkg::CNT_ONE)
        else $error("error count did not step");

    cnt_clear_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && clear_i |=> count_o == slbc_pkg::CNT_RESET)
        else $error("error count not cleared");

endmodule : slbc_err_counter

`default_nettype wire

//--- core/slbc_pkg.sv
// constants, register map and state codes for the serial link self-test
// checker; assumes a single 25 MHz core clock that stands for the pixel clock
//
// Operation
// - test starts from the enable pin or the configuration register
// - test clock: pixel clock or internal oscillator, by pin or register
// - active test sends an enable over the back channel, waking the far end
// - once locked, every nonzero payload is recorded as an error
// - both ends in test and locked: result pin high, checking begins
// - each errored frame pulls the result pin low briefly
// - after the test the pin holds the outcome until a new test
// - losing lock clears the error count
// - test lasts while the enable pin or the register enable bit is high; both low returns to normal
// - lock status output stays valid throughout the test
// - leaving the test steps the adaptive equalizer once
// - forward error count is readable at offset forward_link_error_count
`default_nettype none

package slbc_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int unsigned PAYLOAD_W = 35;
    localparam int unsigned CNT_W = 8;
    localparam int unsigned REG_ADDR_W = 8;
    localparam int unsigned REG_DATA_W = 8;

    // ------------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------------
    localparam logic [REG_ADDR_W-1:0] ERR_COUNT_ADDR = 8'h25;
    localparam logic [REG_ADDR_W-1:0] TEST_CFG_ADDR = 8'h24;
    localparam int unsigned CFG_ENABLE_BIT = 0;
    localparam int unsigned CFG_CLK_SEL_BIT = 1;
    localparam logic [REG_DATA_W-1:0] CFG_RESET = 8'h00;
    localparam logic [REG_DATA_W-1:0] CFG_MASK = 8'h03;
    localparam logic [REG_DATA_W-1:0] RDATA_RESET = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

    // ------------------------------------------------------------------
    // test sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT_LOCK = 2'b01,
        ST_CHECK = 2'b10
    } slbc_state_e;

endpackage : slbc_pkg

`default_nettype wire

//--- core/slbc_top.sv
// receiver-side self-test checker for the serial video link
// assumes recovered frames, lock and far-end test status arrive on clk_i;
// the enable and clock-select pins are asynchronous and are synchronised
`default_nettype none

module slbc_top (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic test_enable_pin_i,
    input wire logic test_clock_select_pin_i,
    input wire logic lock_i,
    input wire logic remote_in_test_i,
    input wire logic frame_valid_i,
    input wire logic [slbc_pkg::PAYLOAD_W-1:0] frame_data_i,
    input wire logic [slbc_pkg::REG_ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [slbc_pkg::REG_DATA_W-1:0] reg_wdata_i,
    output logic [slbc_pkg::REG_DATA_W-1:0] reg_rdata_o,
    output logic result_pin_o,
    output logic bc_test_enable_o,
    output logic internal_oscillator_sel_o,
    output logic lock_o,
    output logic test_active_o,
    output logic adaptive_equalizer_step_o
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic en_meta_reg;
    logic en_sync_reg;
    logic clk_sel_meta_reg;
    logic clk_sel_sync_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            en_meta_reg <= 1'b0;
            en_sync_reg <= 1'b0;
            clk_sel_meta_reg <= 1'b0;
            clk_sel_sync_reg <= 1'b0;
        end else if (ce_i) begin
            en_meta_reg <= test_enable_pin_i;
            en_sync_reg <= en_meta_reg;
            clk_sel_meta_reg <= test_clock_select_pin_i;
            clk_sel_sync_reg <= clk_sel_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------------
    logic [slbc_pkg::REG_DATA_W-1:0] cfg_reg;
    logic [slbc_pkg::CNT_W-1:0] err_count;

    // only the two defined bits are kept; the rest read as zero
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_reg <= slbc_pkg::CFG_RESET;
        end else if (ce_i && reg_wr_i
                     && reg_addr_i == slbc_pkg::TEST_CFG_ADDR) begin
            cfg_reg <= reg_wdata_i & slbc_pkg::CFG_MASK;
        end
    end

    // registered read; unmapped offsets and the count are read-only
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= slbc_pkg::RDATA_RESET;
        end else if (ce_i && reg_rd_i) begin
            unique case (reg_addr_i)
                slbc_pkg::ERR_COUNT_ADDR: reg_rdata_o <= err_count;
                slbc_pkg::TEST_CFG_ADDR: reg_rdata_o <= cfg_reg;
                default: reg_rdata_o <= slbc_pkg::RDATA_RESET;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------------
    logic test_req;
    logic frame_err;
    slbc_pkg::slbc_state_e state_reg;
    logic err_seen_reg;

    assign test_req = en_sync_reg
                      || cfg_reg[slbc_pkg::CFG_ENABLE_BIT];
    // payload bits 1..35 sit at indices 0..34; any one set is an error
    assign frame_err = state_reg == slbc_pkg::ST_CHECK && lock_i
                       && frame_valid_i && (|frame_data_i);

    // ------------------------------------------------------------------
    // test sequencer
    // ------------------------------------------------------------------
    // lock loss drops back to waiting so no stale frame is checked
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= slbc_pkg::ST_IDLE;
        end else if (ce_i) begin
            unique case (state_reg)
                slbc_pkg::ST_IDLE: begin
                    if (test_req) begin
                        state_reg <= slbc_pkg::ST_WAIT_LOCK;
                    end
                end
                slbc_pkg::ST_WAIT_LOCK: begin
                    if (!test_req) begin
                        state_reg <= slbc_pkg::ST_IDLE;
                    end else if (lock_i && remote_in_test_i) begin
                        state_reg <= slbc_pkg::ST_CHECK;
                    end
                end
                slbc_pkg::ST_CHECK: begin
                    if (!test_req) begin
                        state_reg <= slbc_pkg::ST_IDLE;
                    end else if (!lock_i) begin
                        state_reg <= slbc_pkg::ST_WAIT_LOCK;
                    end
                end
                default: state_reg <= slbc_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // outcome tracking
    // ------------------------------------------------------------------
    // sticky over the whole run, cleared only when a new test starts
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            err_seen_reg <= 1'b0;
        end else if (ce_i) begin
            if (frame_err) begin
                err_seen_reg <= 1'b1;
            end else if (state_reg == slbc_pkg::ST_IDLE && test_req) begin
                err_seen_reg <= 1'b0;
            end
        end
    end

    // low pulse is one core cycle: the finest step this clock can give
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            result_pin_o <= 1'b0;
        end else if (ce_i) begin
            unique case (state_reg)
                slbc_pkg::ST_IDLE: begin
                    if (test_req) begin
                        result_pin_o <= 1'b0;
                    end
                end
                slbc_pkg::ST_WAIT_LOCK: begin
                    if (test_req && lock_i && remote_in_test_i) begin
                        result_pin_o <= 1'b1;
                    end
                end
                slbc_pkg::ST_CHECK: begin
                    if (!test_req) begin
                        result_pin_o <= !(err_seen_reg || frame_err);
                    end else begin
                        result_pin_o <= !frame_err;
                    end
                end
                default: result_pin_o <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // error counter
    // ------------------------------------------------------------------
    slbc_err_counter u_err_counter (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .clear_i(!lock_i || (state_reg == slbc_pkg::ST_IDLE && test_req)),
        .inc_i(frame_err),
        .count_o(err_count)
    );

    // ------------------------------------------------------------------
    // status and side outputs
    // ------------------------------------------------------------------
    // equalizer step fires on the single cycle that leaves the test
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bc_test_enable_o <= 1'b0;
            internal_oscillator_sel_o <= 1'b0;
            lock_o <= 1'b0;
            test_active_o <= 1'b0;
            adaptive_equalizer_step_o <= 1'b0;
        end else if (ce_i) begin
            bc_test_enable_o <= test_req;
            internal_oscillator_sel_o <= clk_sel_sync_reg
                || cfg_reg[slbc_pkg::CFG_CLK_SEL_BIT];
            lock_o <= lock_i;
            test_active_o <= state_reg == slbc_pkg::ST_CHECK;
            adaptive_equalizer_step_o <= state_reg != slbc_pkg::ST_IDLE
                && !test_req;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_ready_to_check;
        ce_i && state_reg == slbc_pkg::ST_WAIT_LOCK && test_req
        && lock_i && remote_in_test_i;
    endsequence

    sequence s_checking;
        state_reg == slbc_pkg::ST_CHECK && result_pin_o;
    endsequence

    test_entry_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && state_reg == slbc_pkg::ST_IDLE && test_req
        |=> state_reg == slbc_pkg::ST_WAIT_LOCK)
        else $error("test request not taken");

    check_start_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        s_ready_to_check |=> s_checking)
        else $error("checking did not start with result high");

    back_enable_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(bc_test_enable_o) |-> $past(test_req))
        else $error("back channel enable without request");

    err_pulse_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && frame_err |=> !result_pin_o)
        else $error("errored frame did not pull result low");

    result_hold_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        state_reg == slbc_pkg::ST_IDLE && !test_req |=> $stable(result_pin_o))
        else $error("held result changed outside a test");

    final_result_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && state_reg == slbc_pkg::ST_CHECK && !test_req
        |=> result_pin_o == !$past(err_seen_reg || frame_err))
        else $error("final result does not match errors seen");

    lock_clear_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && !lock_i |=> err_count == slbc_pkg::CNT_RESET)
        else $error("count not cleared on lock loss");

    lock_out_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i |=> lock_o == $past(lock_i))
        else $error("lock status output stale");

    eq_step_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && state_reg != slbc_pkg::ST_IDLE && !test_req
        |=> adaptive_equalizer_step_o && state_reg == slbc_pkg::ST_IDLE)
        else $error("equalizer not stepped on test exit");

    clk_sel_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && cfg_reg[slbc_pkg::CFG_CLK_SEL_BIT] |=> internal_oscillator_sel_o)
        else $error("register clock select ignored");

    test_exit_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        ce_i && !test_req |=> state_reg == slbc_pkg::ST_IDLE)
        else $error("test did not end when enable dropped");

endmodule : slbc_top

`default_nettype wire

//--- test/slbc_remote_model.sv
// stand-in for the far serializer during the link self-test
// assumes the back-channel request and all frames share the core clock
`default_nettype none

module slbc_remote_model (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic bc_test_enable_i,
    input wire logic inject_i,
    input wire logic [slbc_pkg::PAYLOAD_W-1:0] err_data_i,
    input wire logic drop_lock_i,
    input wire logic [3:0] strap_i,
    output logic remote_in_test_o,
    output logic lock_o,
    output logic frame_valid_o,
    output logic [slbc_pkg::PAYLOAD_W-1:0] frame_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wake_reg;
    logic awake_reg;
    logic [7:0] crc_err_reg;
    logic crc_err;
    assign crc_err = 1'b0; // ideal back channel, never errs

    // wake takes three cycles so the checker sees a real wait for lock
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wake_reg <= 2'h0;
            awake_reg <= 1'b0;
            remote_in_test_o <= 1'b0;
            lock_o <= 1'b0;
        end else begin
            // the far end wakes only when the straps are as required
            wake_reg <= {wake_reg[0],
                bc_test_enable_i && strap_i == 4'h1};
            awake_reg <= awake_reg | wake_reg[1];
            remote_in_test_o <= wake_reg[1];
            lock_o <= (awake_reg | wake_reg[1]) & ~drop_lock_i;
        end
    end

    // zero payload at full rate; noise outside test, not a stale value
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_valid_o <= 1'b0;
            frame_data_o <= '0;
        end else begin
            frame_valid_o <= remote_in_test_o;
            frame_data_o <= !remote_in_test_o ? ~frame_data_o :
                inject_i ? err_data_i : '0;
        end
    end

    // back-channel crc tally, cleared when a test begins
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            crc_err_reg <= 8'h00;
        end else if (bc_test_enable_i && !remote_in_test_o) begin
            crc_err_reg <= 8'h00;
        end else if (awake_reg && crc_err) begin
            crc_err_reg <= crc_err_reg + 8'h01;
        end
    end
endmodule : slbc_remote_model

`default_nettype wire

//--- test/slbc_tb.sv
// self-checking bench for the serial link self-test checker
// assumes the remote model answers the back-channel request
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn_n = 1'b0, en_pin = 1'b0, cs_pin = 1'b0;
    logic wr = 1'b0, rd = 1'b0, rd_d = 1'b0, inj = 1'b0, drop = 1'b0;
    logic watch = 1'b0, ce = 1'b1;
    // straps held as the far side requires: zero high, three to one low
    logic [3:0] strap_lines = 4'h1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, low_cnt = 8'h00;
    logic [34:0] errd = '0;
    logic [7:0] rd_q[$];
    wire logic lock, remote, fv, res, bc_en, osc, lock_q, act, eq;
    wire logic [34:0] fdata;
    wire logic [7:0] rdata;
    int n_errors = 0, checked = 0, seed;

    always #20 clk = ~clk;

    slbc_top dut_u (.clk_i(clk), .rstn_i(rstn_n), .ce_i(ce),
        .test_enable_pin_i(en_pin), .test_clock_select_pin_i(cs_pin),
        .lock_i(lock), .remote_in_test_i(remote), .frame_valid_i(fv),
        .frame_data_i(fdata), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .result_pin_o(res), .bc_test_enable_o(bc_en),
        .internal_oscillator_sel_o(osc), .lock_o(lock_q),
        .test_active_o(act), .adaptive_equalizer_step_o(eq));

    slbc_remote_model far_u (.clk_i(clk), .rstn_i(rstn_n),
        .bc_test_enable_i(bc_en), .inject_i(inj), .err_data_i(errd),
        .strap_i(strap_lines),
        .drop_lock_i(drop), .remote_in_test_o(remote), .lock_o(lock),
        .frame_valid_o(fv), .frame_data_o(fdata));

    // ------------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------------
    task automatic fail(input string msg);
        n_errors++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask : fail

    task automatic chk_bit(input logic a, input logic b, input string m);
        checked++;
        if (a !== b) fail(m);
    endtask : chk_bit

    task automatic chk_byte(input logic [7:0] a, input logic [7:0] b,
            input string m);
        checked++;
        if (a !== b) fail(m);
    endtask : chk_byte

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // read data lands one edge after the strobe; low cycles count errors
    always @(posedge clk) begin
        if (rd_d) chk_byte(rdata, rd_q.pop_front(), "read data");
        rd_d <= rd;
        if (watch && res !== 1'b1) low_cnt <= low_cnt + 8'h01;
    end

    // ------------------------------------------------------------------
    // bus and test sequences
    // ------------------------------------------------------------------
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : reg_read

    task automatic run_test(input bit pin, input bit err, input bit dl);
        int w, r;
        logic [7:0] nexp;
        logic [34:0] d;
        nexp = 8'h00;
        if (pin) begin
            @(posedge clk);
            en_pin <= 1'b1;
        end else reg_write(slbc_pkg::TEST_CFG_ADDR, 8'h01);
        for (w = 0; w < 20 && bc_en !== 1'b1; w++) @(posedge clk);
        chk_bit(bc_en, 1'b1, "back-channel enable");
        chk_bit(res, 1'b0, "result cleared at start");
        for (w = 0; w < 20 && act !== 1'b1; w++) @(posedge clk);
        chk_bit(res, 1'b1, "result high when checking");
        chk_bit(lock_q, 1'b1, "lock status");
        low_cnt <= 8'h00;
        watch <= 1'b1;
        for (w = 0; w < 24; w++) begin
            @(posedge clk);
            r = $random(seed);
            d = 35'({$random(seed), $random(seed)});
            inj <= err && r[0] && d != '0;
            errd <= d;
            if (err && r[0] && d != '0) nexp = nexp + 8'h01;
        end
        @(posedge clk);
        inj <= 1'b0;
        repeat (4) @(posedge clk);
        watch <= 1'b0;
        @(posedge clk);
        chk_byte(low_cnt, nexp, "low pulse count");
        reg_read(slbc_pkg::ERR_COUNT_ADDR, nexp);
        if (dl) begin
            @(posedge clk);
            drop <= 1'b1;
            repeat (3) @(posedge clk);
            drop <= 1'b0;
            reg_read(slbc_pkg::ERR_COUNT_ADDR, 8'h00);
            for (w = 0; w < 20 && act !== 1'b1; w++) @(posedge clk);
            chk_bit(lock_q, 1'b1, "lock back");
        end
        if (pin) begin
            @(posedge clk);
            en_pin <= 1'b0;
        end else reg_write(slbc_pkg::TEST_CFG_ADDR, 8'h00);
        for (w = 0; w < 20 && eq !== 1'b1; w++) @(posedge clk);
        chk_bit(eq, 1'b1, "equalizer step");
        chk_bit(res, nexp == 8'h00, "final result");
        repeat (6) @(posedge clk);
        chk_bit(res, nexp == 8'h00, "result held");
        chk_bit(act, 1'b0, "back to normal");
        $display("test done pin=%0d err=%0d drop=%0d", pin, err, dl);
    endtask : run_test

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        seed = 62741;
        repeat (3) @(posedge clk);
        rstn_n <= 1'b1;
        @(posedge clk);
        reg_read(slbc_pkg::ERR_COUNT_ADDR, 8'h00);
        reg_read(slbc_pkg::TEST_CFG_ADDR, 8'h00);
        reg_read(8'h30, 8'h00);
        reg_write(slbc_pkg::ERR_COUNT_ADDR, 8'haa);
        reg_read(slbc_pkg::ERR_COUNT_ADDR, 8'h00);
        // a write while the clock enable is low must leave no trace
        ce <= 1'b0;
        reg_write(slbc_pkg::TEST_CFG_ADDR, 8'h01);
        repeat (3) @(posedge clk);
        chk_bit(bc_en, 1'b0, "no test while clock enable low");
        ce <= 1'b1;
        reg_read(slbc_pkg::TEST_CFG_ADDR, 8'h00);
        $display("test done clock enable freeze");
        reg_write(slbc_pkg::TEST_CFG_ADDR, 8'hfe);
        reg_read(slbc_pkg::TEST_CFG_ADDR, 8'h02);
        chk_bit(osc, 1'b1, "oscillator by register");
        reg_write(slbc_pkg::TEST_CFG_ADDR, 8'h00);
        cs_pin <= 1'b1;
        repeat (5) @(posedge clk);
        chk_bit(osc, 1'b1, "oscillator by pin");
        cs_pin <= 1'b0;
        repeat (5) @(posedge clk);
        chk_bit(osc, 1'b0, "pixel clock again");
        $display("test done registers and clock select");
        run_test(1'b0, 1'b1, 1'b0);
        run_test(1'b1, 1'b0, 1'b0);
        run_test(1'b1, 1'b1, 1'b1);
        run_test(1'b0, 1'b0, 1'b0);
        complete_run;
    end

    initial begin
        #800000;
        n_errors++;
        complete_run;
    end
endmodule : testbench

`default_nettype wire
